// ### design/aop_pkg.sv
// package for the angle output pwm timing block
// assumes a 40 MHz system clock and an AXI4-Lite master on the same clock
package aop_pkg;
	// clock and timing
	localparam int CLK_HZ            = 40_000_000;
	localparam int ANGLE_REFRESH_NS  = 1000;
	localparam int ANGLE_REFRESH_CYC = (ANGLE_REFRESH_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int SNAP_MAX_NS       = 125;
	localparam int SNAP_MAX_CYC      = (SNAP_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int ZCD_US            = 32;
	localparam int GAUSS_US          = 128;
	localparam int SPI_FRAME_BITS    = 16;
	// pwm base period at 3125 Hz and the per-step stretch
	localparam int PWM_BASE_HZ       = 3125;
	localparam int PWM_BASE_CYC      = CLK_HZ / PWM_BASE_HZ;
	localparam int PWM_STEP_CYC      = 100;
	// duty limits in thousandths, error duty step in hundred-thousandths
	localparam int DUTY_MIN_PM       = 50;
	localparam int DUTY_MAX_PM       = 950;
	localparam int DUTY_ERR_BASE_PM  = 50;
	localparam int DUTY_ERR_STEP_PM  = 5625;
	localparam int NUM_ERR           = 11;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ANGLE  = 8'h08;
	localparam logic [7:0] OFS_AUX    = 8'h0C;
	localparam logic [7:0] OFS_ERRIN  = 8'h10;
	localparam logic [7:0] OFS_WADR   = 8'h14;
	// ctrl fields
	localparam int CTRL_PEO_BIT   = 0;
	localparam int CTRL_PES_BIT   = 1;
	localparam int CTRL_FMT_BIT   = 2;
	localparam int CTRL_STEP_LSB  = 4;
	localparam int CTRL_BAND_LSB  = 8;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
	localparam logic [31:0] WADR_RST  = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLV   = 2'b10;

	typedef enum logic [1:0] {
		AOP_RUN  = 2'b00,
		AOP_SLOW = 2'b01,
		AOP_HIZ  = 2'b10
	} aop_mode_t;
endpackage : aop_pkg

// ### design/aop_tick.sv
// periodic one-cycle enable divider
// assumes the single system clock with synchronous active low reset
module aop_tick
	import aop_pkg::*;
#(
	parameter int DIV = 40
) (
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	output logic      o_tick
);
	localparam int W = $clog2(DIV + 1);
	logic [W-1:0] cnt_ff;
	wire          wrap = (cnt_ff == W'(DIV - 1));

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt_ff <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_ff <= wrap ? '0 : cnt_ff + W'(1);
			o_tick <= wrap;
		end
	end
endmodule : aop_tick

// ### design/aop_spi_snap.sv
// serial snapshot and shift unit for angle readout
// assumes spi pins already synchronised into the system clock
module aop_spi_snap
	import aop_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_cs_fall,
	input  wire logic        i_sclk_fall,
	input  wire logic        i_cs_n,
	input  wire logic        i_fmt15,
	input  wire logic [14:0] i_angle15,
	input  wire logic [3:0]  i_flags,
	output logic             o_miso,
	output logic [4:0]       o_bits
);
	logic [15:0] sh_ff;
	wire  [15:0] word = i_fmt15 ? {1'b0, i_angle15}
		: {i_flags, i_angle15[14:3]};

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			sh_ff  <= '0;
			o_miso <= 1'b0;
			o_bits <= '0;
		end else if (i_cs_fall) begin
			sh_ff  <= word;
			o_miso <= word[15];
			o_bits <= '0;
		end else if (!i_cs_n && i_sclk_fall && o_bits != 5'(SPI_FRAME_BITS)) begin
			sh_ff  <= {sh_ff[14:0], 1'b0};
			o_miso <= sh_ff[14];
			o_bits <= o_bits + 5'd1;
		end
	end
endmodule : aop_spi_snap

// ### design/aop_top.sv
// angle output pwm timing: refresh cadence, spi snapshot, pwm encoder
// assumes AXI4-Lite master on i_mclk, spi pins asynchronous
// ==========================================================
// Notes on behaviour
// - a fresh angle is latched every angle refresh period of one microsecond
// - serial word carries 12-bit angle plus flags, or 15-bit angle alone
// - a serial angle read takes sixteen serial clocks
// - pwm always encodes the angle at 12-bit resolution
// - incremental outputs update once per refresh and only on change
// - chip select fall snapshots data path within 125 ns
// - zero-crossing angle every 32 us, field strength every 128 us
// - reset reloads shadow config including origin trim and register defaults
// - extended write address pointer clears on reset
// - normal duty limited to 5 to 95 percent
// - constant low and constant high never mean an angle
// - period starts with a rising edge; falling edge carries angle
// - errors only affect the pin when error output is enabled
// - error style 0 tristates the pin until reset
// - error style 1 halves frequency while error exists
// - an error shorter than a period is reported in the next one
// - in halved mode duty is a fixed code per error
// - highest priority error reported, 5 to 72.5 percent
// - carrier chosen by band and step, 3125 Hz down to about 22 Hz
module aop_top
	import aop_pkg::*;
#(
	parameter logic [11:0] ZERO_TRIM_NV = 12'h000,
	parameter logic [31:0] CTRL_NV      = CTRL_RST
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic [14:0] i_angle_raw,
	input  wire logic [15:0] i_zcd_raw,
	input  wire logic [15:0] i_gauss_raw,
	input  wire logic [10:0] i_err_raw,
	input  wire logic        i_spi_cs_n,
	input  wire logic        i_spi_sclk,
	output logic             o_spi_miso,
	output logic             o_pwm,
	output logic             o_pwm_oe_n,
	output logic [11:0]      o_inc_angle,
	output logic             o_inc_upd,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ==========================================================
	// cadence enables
	logic tick_ang;
	logic tick_zcd;
	logic tick_gauss;
	aop_tick #(.DIV(ANGLE_REFRESH_CYC)) u_ang (
		.i_mclk (i_mclk),
		.i_rst_n(i_rst_n),
		.o_tick (tick_ang)
	);
	aop_tick #(.DIV(ZCD_US * ANGLE_REFRESH_CYC)) u_zcd (
		.i_mclk (i_mclk),
		.i_rst_n(i_rst_n),
		.o_tick (tick_zcd)
	);
	aop_tick #(.DIV(GAUSS_US * ANGLE_REFRESH_CYC)) u_gauss (
		.i_mclk (i_mclk),
		.i_rst_n(i_rst_n),
		.o_tick (tick_gauss)
	);

	// ==========================================================
	// registers
	logic [31:0] ctrl_ff;
	logic [31:0] wadr_ff;
	logic [11:0] trim_ff;
	logic [14:0] angle_ff;
	logic [15:0] zcd_ff;
	logic [15:0] gauss_ff;
	wire  [14:0] angle_trim = i_angle_raw - {trim_ff, 3'b000};

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			angle_ff <= '0;
			zcd_ff   <= '0;
			gauss_ff <= '0;
		end else begin
			if (tick_ang)
				angle_ff <= angle_trim;
			if (tick_zcd)
				zcd_ff <= i_zcd_raw;
			if (tick_gauss)
				gauss_ff <= i_gauss_raw;
		end
	end

	// incremental outputs follow angle changes at refresh
	wire inc_chg = tick_ang && (angle_trim[14:3] != o_inc_angle);
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_inc_angle <= '0;
			o_inc_upd   <= 1'b0;
		end else begin
			o_inc_upd <= inc_chg;
			if (inc_chg)
				o_inc_angle <= angle_trim[14:3];
		end
	end

	// ==========================================================
	// spi pins synchronised, then snapshot and shift
	logic [1:0] cs_sy_ff;
	logic [1:0] sck_sy_ff;
	logic       cs_d_ff;
	logic       sck_d_ff;
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cs_sy_ff  <= 2'b11;
			sck_sy_ff <= 2'b11;
			cs_d_ff   <= 1'b1;
			sck_d_ff  <= 1'b1;
		end else begin
			cs_sy_ff  <= {cs_sy_ff[0], i_spi_cs_n};
			sck_sy_ff <= {sck_sy_ff[0], i_spi_sclk};
			cs_d_ff   <= cs_sy_ff[1];
			sck_d_ff  <= sck_sy_ff[1];
		end
	end
	wire cs_fall   = cs_d_ff && !cs_sy_ff[1];
	wire sclk_fall = sck_d_ff && !sck_sy_ff[1];
	wire [4:0] spi_bits;
	aop_spi_snap u_spi (
		.i_mclk     (i_mclk),
		.i_rst_n    (i_rst_n),
		.i_cs_fall  (cs_fall),
		.i_sclk_fall(sclk_fall),
		.i_cs_n     (cs_sy_ff[1]),
		.i_fmt15    (ctrl_ff[CTRL_FMT_BIT]),
		.i_angle15  (angle_ff),
		.i_flags    (i_err_raw[3:0]),
		.o_miso     (o_spi_miso),
		.o_bits     (spi_bits)
	);

	// ==========================================================
	// pwm period and duty
	wire        peo  = ctrl_ff[CTRL_PEO_BIT];
	wire        pes  = ctrl_ff[CTRL_PES_BIT];
	wire [3:0]  step = ctrl_ff[CTRL_STEP_LSB +: 4];
	wire [2:0]  band = ctrl_ff[CTRL_BAND_LSB +: 3];
	// period grows linearly with step and doubles per band
	wire [31:0] per_base = 32'(PWM_BASE_CYC) + 32'(step) * 32'(PWM_STEP_CYC);
	wire [31:0] per_cfg  = per_base << band;

	logic [31:0] cnt_ff;
	logic [31:0] per_ff;
	logic [31:0] hi_ff;
	logic [10:0] err_lat_ff;
	aop_mode_t   mode_ff;
	wire         last = (cnt_ff >= per_ff - 32'd1);
	wire         err_any = |(err_lat_ff | i_err_raw);

	// priority pick: lowest index is highest priority
	logic [3:0] err_idx;
	always_comb begin
		err_idx = 4'd0;
		for (int k = NUM_ERR - 1; k >= 0; k--)
			if (err_lat_ff[k] | i_err_raw[k])
				err_idx = 4'(k);
	end

	wire [63:0] ang_mul = 64'(angle_ff[14:3]) * 64'(DUTY_MAX_PM - DUTY_MIN_PM);
	wire [63:0] ang_pm  = 64'(DUTY_MIN_PM) * 64'd4095 + ang_mul;
	// bits from the third on skip two unused priority levels
	wire [3:0]  err_lvl = (err_idx < 4'd2) ? err_idx : err_idx + 4'd2;
	wire [63:0] err_pm  = 64'(DUTY_ERR_BASE_PM) * 64'd100
		+ 64'(err_lvl) * 64'(DUTY_ERR_STEP_PM);
	wire        go_slow = peo && pes && err_any;
	wire [31:0] nxt_per = go_slow ? (per_cfg << 1) : per_cfg;
	wire [31:0] nxt_hi  = go_slow
		? 32'(64'(nxt_per) * err_pm / 64'd100000)
		: 32'(64'(nxt_per) * ang_pm / 64'd4095000);
	wire        go_hiz  = peo && !pes && err_any;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt_ff     <= '0;
			per_ff     <= 32'(PWM_BASE_CYC);
			hi_ff      <= 32'(PWM_BASE_CYC / 20);
			err_lat_ff <= '0;
			mode_ff    <= AOP_RUN;
		end else begin
			if (last) begin
				cnt_ff     <= '0;
				per_ff     <= nxt_per;
				hi_ff      <= nxt_hi;
				err_lat_ff <= '0;
				if (mode_ff != AOP_HIZ)
					mode_ff <= go_hiz ? AOP_HIZ
						: (go_slow ? AOP_SLOW : AOP_RUN);
			end else begin
				cnt_ff     <= cnt_ff + 32'd1;
				err_lat_ff <= err_lat_ff | i_err_raw;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_pwm      <= 1'b0;
			o_pwm_oe_n <= 1'b0;
		end else begin
			o_pwm_oe_n <= (mode_ff == AOP_HIZ);
			o_pwm      <= (cnt_ff < hi_ff);
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	logic        aw_ff;
	logic        w_ff;
	logic [7:0]  awa_ff;
	logic [31:0] wd_ff;
	logic [3:0]  ws_ff;
	wire         do_wr  = aw_ff && w_ff && !s_axi_bvalid;
	wire         wr_ok  = (awa_ff == OFS_CTRL) || (awa_ff == OFS_WADR);
	wire [31:0]  wmask  = {{8{ws_ff[3]}}, {8{ws_ff[2]}},
		{8{ws_ff[1]}}, {8{ws_ff[0]}}};
	wire [31:0]  ctrl_w = (ctrl_ff & ~wmask) | (wd_ff & wmask);
	wire [31:0]  wadr_w = (wadr_ff & ~wmask) | (wd_ff & wmask);

	wire         nxt_aw = !do_wr && (aw_ff || s_axi_awvalid);
	wire         nxt_w  = !do_wr && (w_ff || s_axi_wvalid);

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			aw_ff        <= 1'b0;
			w_ff         <= 1'b0;
			awa_ff       <= '0;
			wd_ff        <= '0;
			ws_ff        <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			ctrl_ff      <= CTRL_NV;
			trim_ff      <= ZERO_TRIM_NV;
			wadr_ff      <= WADR_RST;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			s_axi_awready <= !nxt_aw;
			s_axi_wready  <= !nxt_w;
			if (s_axi_awvalid && !aw_ff) begin
				aw_ff  <= 1'b1;
				awa_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_ff) begin
				w_ff  <= 1'b1;
				wd_ff <= s_axi_wdata;
				ws_ff <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_ff        <= 1'b0;
				w_ff         <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLV;
				if (awa_ff == OFS_CTRL)
					ctrl_ff <= ctrl_w;
				if (awa_ff == OFS_WADR)
					wadr_ff <= wadr_w;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_ok  = 1'b1;
		case (s_axi_araddr)
			OFS_CTRL:   rd_mux = ctrl_ff;
			OFS_STATUS: rd_mux = {22'd0, spi_bits, 3'd0, mode_ff};
			OFS_ANGLE:  rd_mux = {17'd0, angle_ff};
			OFS_AUX:    rd_mux = {gauss_ff, zcd_ff};
			OFS_ERRIN:  rd_mux = {21'd0, err_lat_ff};
			OFS_WADR:   rd_mux = wadr_ff;
			default: begin
				rd_mux = '0;
				rd_ok  = 1'b0;
			end
		endcase
	end
	wire nxt_rv = s_axi_rvalid ? !s_axi_rready : s_axi_arvalid;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !nxt_rv;
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLV;
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	a_hiz_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		mode_ff == AOP_HIZ |=> mode_ff == AOP_HIZ)
		else $error("hiz mode left without reset");
	a_pwm_period: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		last |=> cnt_ff == 32'd0 ##1 o_pwm)
		else $error("period does not start high");
	a_spi_snap: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		cs_fall |=> spi_bits == 5'd0)
		else $error("snapshot not taken at chip select");
	a_inc_change: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_inc_upd |-> $past(tick_ang))
		else $error("incremental update off refresh");
	a_per_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!last |=> $stable(per_ff) && $stable(hi_ff))
		else $error("pwm changed mid period");
	a_no_err_eff: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		last && !peo && mode_ff != AOP_HIZ |=> mode_ff == AOP_RUN)
		else $error("error affects pwm while disabled");
	a_slow_double: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		last && go_slow |=> per_ff == ($past(per_cfg) << 1))
		else $error("period not doubled in error");
	a_err_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!last && i_err_raw[0] |=> err_lat_ff[0])
		else $error("brief error not latched");
	c_hiz: cover property (@(posedge i_mclk) mode_ff == AOP_HIZ);
	c_slow: cover property (@(posedge i_mclk) mode_ff == AOP_SLOW);
	c_spi: cover property (@(posedge i_mclk) spi_bits == 5'd16);
endmodule : aop_top

// ### verification/aop_host.sv
// host side model: spi master reading one angle word, pwm period meter
// assumes it shares i_mclk with the design; spi pins idle high
module aop_host (
	input  wire logic i_mclk,
	input  wire logic i_pwm,
	input  wire logic i_miso,
	output logic      o_cs_n,
	output logic      o_sclk
);
	timeunit 1ns;
	timeprecision 100ps;

	// sclk stands high outside frames
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
	end

	// =========================================================
	// spi frame: msb ready at snapshot, one bit per sclk fall
	task automatic spi_read(output logic [15:0] w);
		@(posedge i_mclk);
		o_cs_n <= 1'b0;
		repeat (10) @(posedge i_mclk);
		w[15] = i_miso;
		for (int i = 14; i >= -1; i--) begin
			o_sclk <= 1'b0;
			repeat (10) @(posedge i_mclk);
			o_sclk <= 1'b1;
			if (i >= 0) w[i] = i_miso;
			repeat (10) @(posedge i_mclk);
		end
		o_cs_n <= 1'b1;
		repeat (10) @(posedge i_mclk);
	endtask : spi_read

	// =========================================================
	// pwm meter: cycles counted from the rising edge
	task automatic lvl_wait(input logic l, inout int n);
		do begin
			@(posedge i_mclk);
			n++;
		end while (i_pwm !== l && n < 70000);
	endtask : lvl_wait

	task automatic pwm_meas(output int h0, p0, h1, p1);
		int n;
		n = 0;
		lvl_wait(1'b0, n);
		lvl_wait(1'b1, n);
		n = 0;
		lvl_wait(1'b0, n);
		h0 = n;
		lvl_wait(1'b1, n);
		p0 = n;
		n = 0;
		lvl_wait(1'b0, n);
		h1 = n;
		lvl_wait(1'b1, n);
		p1 = n;
	endtask : pwm_meas
endmodule : aop_host

// ### verification/aop_top_tb.sv
// self-checking bench: axi4-lite register access, spi, pwm, incremental
// assumes aop_top with default parameters and the aop_host model
module aop_top_tb
	import aop_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        i_mclk, i_rst_n, i_spi_cs_n, i_spi_sclk;
	logic [14:0] i_angle_raw;
	logic [15:0] i_zcd_raw, i_gauss_raw;
	logic [10:0] i_err_raw;
	logic        o_spi_miso, o_pwm, o_pwm_oe_n, o_inc_upd;
	logic [11:0] o_inc_angle;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          n_fail = 0, total_checks = 0, gap = 0, since = 0, npls = 0;

	aop_top u_aop_top (.i_mclk, .i_rst_n, .i_angle_raw, .i_zcd_raw,
		.i_gauss_raw, .i_err_raw, .i_spi_cs_n, .i_spi_sclk, .o_spi_miso,
		.o_pwm, .o_pwm_oe_n, .o_inc_angle, .o_inc_upd, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	aop_host u_aop_host (.i_mclk, .i_pwm(o_pwm), .i_miso(o_spi_miso),
		.o_cs_n(i_spi_cs_n), .o_sclk(i_spi_sclk));

	always #12.5 i_mclk = ~i_mclk;

	// spacing of incremental update pulses
	always @(posedge i_mclk) begin
		if (o_inc_upd === 1'b1) begin
			gap <= since;
			since <= 1;
			npls <= npls + 1;
		end else begin
			since <= since + 1;
		end
	end

	// =========================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask : chk

	task automatic near(input string nm, input int e, g, t);
		total_checks++;
		if (g < e - t || g > e + t) begin
			$display("unexpected %s: expected %0d seen %0d", nm, e, g);
			n_fail++;
		end
	endtask : near

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		r = 2'b11;
		@(posedge i_mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n < 100) begin
			@(posedge i_mclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				n = 1000;
			end
		end
		if (n < 1000) chk("bvalid", 32'h0000_0001, 32'h0000_0000);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		r = 2'b11;
		@(posedge i_mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (n < 100) begin
			@(posedge i_mclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				n = 1000;
			end
		end
		if (n < 1000) chk("rvalid", 32'h0000_0001, 32'h0000_0000);
	endtask : axi_rd

	task automatic hold_chk(input logic e, input int c);
		logic bad;
		bad = 1'b0;
		repeat (c) begin
			@(posedge i_mclk);
			if (o_pwm_oe_n !== e) bad = 1'b1;
		end
		chk("oe_n held", 32'h0000_0000, 32'(bad));
	endtask : hold_chk

	task automatic do_reset();
		@(posedge i_mclk);
		i_rst_n <= 1'b0;
		repeat (5) @(posedge i_mclk);
		i_rst_n <= 1'b1;
	endtask : do_reset

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (99000) @(posedge i_mclk);
		n_fail++;
		$display("unexpected run time: expected end seen timeout");
		wrap_up();
	end

	// =========================================================
	// tests
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] w;
		int          h0, p0, h1, p1, k;
		i_mclk = 1'b0;
		i_rst_n = 1'b0;
		i_angle_raw = 15'h0000;
		i_zcd_raw = 16'h0000;
		i_gauss_raw = 16'h0000;
		i_err_raw = 11'h000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		do_reset();
		axi_rd(OFS_CTRL, d, r);
		chk("ctrl reset", CTRL_RST, d);
		axi_rd(OFS_WADR, d, r);
		chk("wadr reset", WADR_RST, d);
		axi_wr(OFS_WADR, 32'h0000_0005, r);
		axi_wr(8'h20, 32'h0000_0001, r);
		chk("unmapped bresp", 32'(RESP_SLV), 32'(r));
		axi_rd(8'h20, d, r);
		chk("unmapped rresp", 32'(RESP_SLV), 32'(r));
		axi_rd(OFS_WADR, d, r);
		chk("wadr", 32'h0000_0005, d);
		// incremental outputs
		repeat (100) @(posedge i_mclk);
		k = npls;
		repeat (200) @(posedge i_mclk);
		chk("inc idle", 32'(k), 32'(npls));
		i_angle_raw <= 15'h1238;
		repeat (200) @(posedge i_mclk);
		chk("inc count", 32'(k + 1), 32'(npls));
		chk("inc angle", 32'h0000_0247, 32'(o_inc_angle));
		for (k = 0; k < 400; k++) begin
			i_angle_raw <= i_angle_raw + 15'h0008;
			@(posedge i_mclk);
		end
		chk("inc gap", 32'(ANGLE_REFRESH_CYC), 32'(gap));
		// aux readings
		i_zcd_raw <= 16'h1111;
		i_gauss_raw <= 16'h2222;
		repeat (1300) @(posedge i_mclk);
		axi_rd(OFS_AUX, d, r);
		chk("zcd", 32'h0000_1111, {16'h0000, d[15:0]});
		repeat (3900) @(posedge i_mclk);
		axi_rd(OFS_AUX, d, r);
		chk("aux", 32'h2222_1111, d);
		// spi, angle changes after the snapshot
		i_angle_raw <= 15'h5A5A;
		axi_wr(OFS_CTRL, 32'h0000_0005, r);
		repeat (100) @(posedge i_mclk);
		fork
			u_aop_host.spi_read(w);
			begin
				repeat (9) @(posedge i_mclk);
				i_angle_raw <= 15'h2222;
			end
		join
		chk("spi fmt15", 32'h0000_5A5A, 32'(w));
		i_angle_raw <= 15'h5A5A;
		axi_wr(OFS_CTRL, 32'h0000_0000, r);
		i_err_raw <= 11'h004;
		repeat (100) @(posedge i_mclk);
		u_aop_host.spi_read(w);
		chk("spi fmt12", 32'h0000_4B4B, 32'(w));
		hold_chk(1'b0, 500);
		i_err_raw <= 11'h000;
		do_reset();
		axi_rd(OFS_CTRL, d, r);
		chk("ctrl again", CTRL_RST, d);
		axi_rd(OFS_WADR, d, r);
		chk("wadr again", WADR_RST, d);
		// pwm, halved frequency on a brief double error
		i_angle_raw <= 15'h7FFF;
		axi_wr(OFS_CTRL, 32'h0000_0003, r);
		k = 0;
		u_aop_host.lvl_wait(1'b0, k);
		u_aop_host.lvl_wait(1'b1, k);
		i_err_raw <= 11'h022;
		repeat (10) @(posedge i_mclk);
		i_err_raw <= 11'h000;
		u_aop_host.pwm_meas(h0, p0, h1, p1);
		near("slow period", 2 * PWM_BASE_CYC, p0, 0);
		near("err duty", PWM_BASE_CYC * 2 * 10625 / 100000, h0, 2);
		near("period", PWM_BASE_CYC, p1, 0);
		near("duty", PWM_BASE_CYC * 95 / 100, h1, 2);
		// pwm, tristate until reset
		axi_wr(OFS_CTRL, 32'h0000_0001, r);
		i_err_raw <= 11'h008;
		k = 0;
		while (o_pwm_oe_n !== 1'b1 && k < 50000) begin
			@(posedge i_mclk);
			k++;
		end
		chk("oe_n error", 32'h0000_0001, 32'(o_pwm_oe_n));
		i_err_raw <= 11'h000;
		hold_chk(1'b1, 2000);
		do_reset();
		@(posedge i_mclk);
		chk("oe_n reset", 32'h0000_0000, 32'(o_pwm_oe_n));
		wrap_up();
	end
endmodule : aop_top_tb
